// ---- rtl/usb_ep_pkg.sv ----
// shared constants for the endpoint handshake and data-toggle control block
// What this block does
// - a SETUP on endpoint zero sets its transmit toggle to one.
// - transmit toggles of endpoints zero and one invert only on host ACK.
// - toggle value 0 means DATA0, value 1 means DATA1.
// - software writes to toggle bits take effect, forcing DATA0 or DATA1.
// - a correct transfer on endpoint zero sets both its states to NAK.
// - setup stage clears the endpoint zero receive toggle.
// - receive toggle inverts only on error-free data with the expected PID.
// - SETUP to a non-disabled endpoint zero is acknowledged, both states NAK.
// - a STALL answer on endpoint zero sets both its states to stall.
// - endpoint one bits 7:4 and endpoint zero bit 3 read zero.
// - endpoint one receive done flag sets on good reception, software clears.
// - endpoint one transmit done flag sets on good transmission, software clears.
// - USB reset, bus or forced, clears endpoint one bits 2:0.
// - endpoint one states: 0 disabled, 1 stall, 2 NAK, 3 valid.
// - good reception on endpoint one sets only its receive state to NAK.
// - good transmission on endpoint one sets only its transmit state to NAK.
// - endpoint zero done flag at bit 7 sets on correct transfer.
// - USB reset clears endpoint zero bits 6:4 and 2:0.
// - interrupt request when a done flag, its mask set, global disable clear.
package usb_ep_pkg;

   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;

   localparam logic [7:0]  OFS_EP0       = 8'h00;
   localparam logic [7:0]  OFS_EP1_RX    = 8'h04;
   localparam logic [7:0]  OFS_EP1_TX    = 8'h08;
   localparam logic [7:0]  OFS_CTRL      = 8'h0c;

   localparam logic [1:0]  ST_DISABLED   = 2'h0;
   localparam logic [1:0]  ST_STALL      = 2'h1;
   localparam logic [1:0]  ST_NAK        = 2'h2;
   localparam logic [1:0]  ST_VALID      = 2'h3;

   localparam int          EP0_DONE_BIT  = 7;
   localparam int          EP0_TXTOG_BIT = 6;
   localparam int          EP0_TXST_LO   = 4;
   localparam int          EP0_RXTOG_BIT = 2;
   localparam int          EP0_RXST_LO   = 0;
   localparam int          EP1_DONE_BIT  = 3;
   localparam int          EP1_TOG_BIT   = 2;
   localparam int          EP1_ST_LO     = 0;
   localparam int          CTRL_FORCE_BIT = 0;
   localparam int          CTRL_MASK_BIT = 1;
   localparam int          CTRL_RST_BIT  = 7;

   localparam logic [31:0] RESET_WORD    = 32'h0000_0000;

   typedef enum logic [2:0] {
      SEL_EP0,
      SEL_EP1_RX,
      SEL_EP1_TX,
      SEL_CTRL,
      SEL_NONE
   } reg_sel_t;

   function automatic reg_sel_t decode_reg(input logic [ADDR_W-1:0] addr);
      case (addr)
         OFS_EP0:    decode_reg = SEL_EP0;
         OFS_EP1_RX: decode_reg = SEL_EP1_RX;
         OFS_EP1_TX: decode_reg = SEL_EP1_TX;
         OFS_CTRL:   decode_reg = SEL_CTRL;
         default:    decode_reg = SEL_NONE;
      endcase
   endfunction

endpackage

// ---- rtl/ep_dir_ctrl.sv ----
// state field and data toggle of one endpoint direction
`timescale 1ns/1ps
module ep_dir_ctrl (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // usb reset, bus or forced
   input  wire logic       usb_rst,
   // software write
   input  wire logic       sw_wr,
   input  wire logic [1:0] sw_state,
   input  wire logic       sw_toggle,
   // hardware events
   input  wire logic       ev_nak,
   input  wire logic       ev_stall,
   input  wire logic       ev_tog_set,
   input  wire logic       ev_tog_clr,
   input  wire logic       ev_tog_flip,
   // current values
   output logic [1:0]      state,
   output logic            toggle
);
   import usb_ep_pkg::*;

   typedef struct packed {
      logic [1:0] state;
      logic       toggle;
   } dir_st_t;

   dir_st_t q, d;

   always_comb begin
      d = q;
      if (sw_wr) begin
         d.state  = sw_state;
         d.toggle = sw_toggle;
      end
      // hardware last so it overrides a same-cycle write
      if (ev_tog_flip) d.toggle = ~q.toggle;
      if (ev_tog_set)  d.toggle = 1'b1;
      if (ev_tog_clr)  d.toggle = 1'b0;
      if (ev_nak)      d.state  = ST_NAK;
      if (ev_stall)    d.state  = ST_STALL;
      if (usb_rst) begin
         d.state  = ST_DISABLED;
         d.toggle = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) q <= '0;
      else          q <= d;
   end

   assign state  = q.state;
   assign toggle = q.toggle;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   usb_rst_clear_a: assert property (usb_rst |=> state == ST_DISABLED && !toggle)
      else $error("usb reset did not clear direction state");
   hw_over_sw_a: assert property (sw_wr && ev_nak && !ev_stall && !usb_rst
                                  |=> state == ST_NAK)
      else $error("software write beat a hardware NAK update");

endmodule // ep_dir_ctrl

// ---- rtl/usb_endpoint_handshake_ctrl.sv ----
// endpoint handshake state, data toggles and transfer flags behind an apb slave
`timescale 1ns/1ps
module usb_endpoint_handshake_ctrl (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // apb slave
   input  wire logic [usb_ep_pkg::ADDR_W-1:0] paddr,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [usb_ep_pkg::DATA_W-1:0] pwdata,
   output logic                              pready,
   output logic [usb_ep_pkg::DATA_W-1:0]     prdata,
   output logic                              pslverr,
   // events from the serial engine, one-cycle pulses
   input  wire logic                         usb_bus_reset,
   input  wire logic                         ev_ep,
   input  wire logic                         ev_setup,
   input  wire logic                         ev_rx_ok,
   input  wire logic                         ev_rx_pid,
   input  wire logic                         ev_tx_ack,
   input  wire logic                         ev_stall_sent,
   // processor side
   input  wire logic                         global_irq_disable,
   output logic                              irq_req,
   // endpoint view for the serial engine
   output logic [1:0]                        ep0_tx_state,
   output logic [1:0]                        ep0_rx_state,
   output logic                              ep0_tx_toggle,
   output logic                              ep0_rx_toggle,
   output logic [1:0]                        ep1_tx_state,
   output logic [1:0]                        ep1_rx_state,
   output logic                              ep1_tx_toggle,
   output logic                              ep1_rx_toggle,
   output logic                              iface_reset
);
   import usb_ep_pkg::*;

   // decode and read mux assume one 32-bit word per register
   if (ADDR_W < 4 || DATA_W != 32) begin : g_width_check
      $error("unsupported apb widths");
   end

   typedef struct packed {
      logic              ep0_done;
      logic              ep1_rx_done;
      logic              ep1_tx_done;
      logic              force_rst;
      logic              done_irq_mask;
      logic [DATA_W-1:0] rdata;
   } main_st_t;

   main_st_t q, d;

   reg_sel_t sel;
   logic     setup_ph;
   logic     wr_acc;
   logic     wr_ep0;
   logic     wr_ep1_rx;
   logic     wr_ep1_tx;
   logic     usb_rst;
   logic     ev0;
   logic     ev1;
   logic     setup0;
   logic     rx0_ok;
   logic     tx0_ok;
   logic     rx1_ok;
   logic     tx1_ok;
   logic     ep0_xfer_ok;
   logic     stall0;

   assign sel      = decode_reg(paddr);
   assign setup_ph = psel && !penable;
   // zero-wait slave: every access phase completes at once
   assign pready   = 1'b1;
   assign wr_acc   = psel && penable && pwrite;
   assign pslverr  = psel && penable && (sel == SEL_NONE);
   assign wr_ep0    = wr_acc && (sel == SEL_EP0);
   assign wr_ep1_rx = wr_acc && (sel == SEL_EP1_RX);
   assign wr_ep1_tx = wr_acc && (sel == SEL_EP1_TX);

   assign usb_rst     = usb_bus_reset || q.force_rst;
   assign iface_reset = usb_rst;

   assign ev0 = !ev_ep && !usb_rst;
   assign ev1 = ev_ep && !usb_rst;

   // disabled endpoint ignores SETUP, reception and ACK; a STALL answer still stalls it
   assign setup0 = ev_setup && ev0 && (ep0_rx_state != ST_DISABLED);
   // a wrong data PID is a repeat: acknowledged upstream, no toggle, no flag
   assign rx0_ok = ev_rx_ok && ev0 && (ep0_rx_state == ST_VALID)
                   && (ev_rx_pid == ep0_rx_toggle);
   assign tx0_ok = ev_tx_ack && ev0 && (ep0_tx_state == ST_VALID);
   assign rx1_ok = ev_rx_ok && ev1 && (ep1_rx_state == ST_VALID)
                   && (ev_rx_pid == ep1_rx_toggle);
   assign tx1_ok = ev_tx_ack && ev1 && (ep1_tx_state == ST_VALID);
   assign ep0_xfer_ok = rx0_ok || tx0_ok;
   assign stall0 = ev_stall_sent && ev0;

   ep_dir_ctrl u_ep0_tx (
      .pclk        (pclk),
      .presetn     (presetn),
      .usb_rst     (usb_rst),
      .sw_wr       (wr_ep0),
      .sw_state    (pwdata[EP0_TXST_LO +: 2]),
      .sw_toggle   (pwdata[EP0_TXTOG_BIT]),
      .ev_nak      (ep0_xfer_ok || setup0),
      .ev_stall    (stall0),
      .ev_tog_set  (setup0),
      .ev_tog_clr  (1'b0),
      .ev_tog_flip (tx0_ok),
      .state       (ep0_tx_state),
      .toggle      (ep0_tx_toggle)
   );

   ep_dir_ctrl u_ep0_rx (
      .pclk        (pclk),
      .presetn     (presetn),
      .usb_rst     (usb_rst),
      .sw_wr       (wr_ep0),
      .sw_state    (pwdata[EP0_RXST_LO +: 2]),
      .sw_toggle   (pwdata[EP0_RXTOG_BIT]),
      .ev_nak      (ep0_xfer_ok || setup0),
      .ev_stall    (stall0),
      .ev_tog_set  (1'b0),
      .ev_tog_clr  (setup0),
      .ev_tog_flip (rx0_ok),
      .state       (ep0_rx_state),
      .toggle      (ep0_rx_toggle)
   );

   ep_dir_ctrl u_ep1_rx (
      .pclk        (pclk),
      .presetn     (presetn),
      .usb_rst     (usb_rst),
      .sw_wr       (wr_ep1_rx),
      .sw_state    (pwdata[EP1_ST_LO +: 2]),
      .sw_toggle   (pwdata[EP1_TOG_BIT]),
      .ev_nak      (rx1_ok),
      .ev_stall    (1'b0),
      .ev_tog_set  (1'b0),
      .ev_tog_clr  (1'b0),
      .ev_tog_flip (rx1_ok),
      .state       (ep1_rx_state),
      .toggle      (ep1_rx_toggle)
   );

   ep_dir_ctrl u_ep1_tx (
      .pclk        (pclk),
      .presetn     (presetn),
      .usb_rst     (usb_rst),
      .sw_wr       (wr_ep1_tx),
      .sw_state    (pwdata[EP1_ST_LO +: 2]),
      .sw_toggle   (pwdata[EP1_TOG_BIT]),
      .ev_nak      (tx1_ok),
      .ev_stall    (1'b0),
      .ev_tog_set  (1'b0),
      .ev_tog_clr  (1'b0),
      .ev_tog_flip (tx1_ok),
      .state       (ep1_tx_state),
      .toggle      (ep1_tx_toggle)
   );

   always_comb begin
      d = q;
      // done flags: writing 0 clears, writing 1 keeps; a set wins
      d.ep0_done    = (q.ep0_done && !(wr_ep0 && !pwdata[EP0_DONE_BIT]))
                      || ep0_xfer_ok;
      d.ep1_rx_done = (q.ep1_rx_done && !(wr_ep1_rx && !pwdata[EP1_DONE_BIT]))
                      || rx1_ok;
      d.ep1_tx_done = (q.ep1_tx_done && !(wr_ep1_tx && !pwdata[EP1_DONE_BIT]))
                      || tx1_ok;
      if (wr_acc && sel == SEL_CTRL) begin
         d.force_rst     = pwdata[CTRL_FORCE_BIT];
         d.done_irq_mask = pwdata[CTRL_MASK_BIT];
      end
      // read data captured in the setup phase, so prdata is a flop
      if (setup_ph) begin
         d.rdata = RESET_WORD;
         case (sel)
            SEL_EP0: begin
               d.rdata[EP0_DONE_BIT]      = q.ep0_done;
               d.rdata[EP0_TXTOG_BIT]     = ep0_tx_toggle;
               d.rdata[EP0_TXST_LO +: 2]  = ep0_tx_state;
               d.rdata[EP0_RXTOG_BIT]     = ep0_rx_toggle;
               d.rdata[EP0_RXST_LO +: 2]  = ep0_rx_state;  // bit 3 stays 0
            end
            SEL_EP1_RX: begin
               d.rdata[EP1_DONE_BIT]      = q.ep1_rx_done;
               d.rdata[EP1_TOG_BIT]       = ep1_rx_toggle;
               d.rdata[EP1_ST_LO +: 2]    = ep1_rx_state;
            end
            SEL_EP1_TX: begin
               d.rdata[EP1_DONE_BIT]      = q.ep1_tx_done;
               d.rdata[EP1_TOG_BIT]       = ep1_tx_toggle;
               d.rdata[EP1_ST_LO +: 2]    = ep1_tx_state;
            end
            SEL_CTRL: begin
               d.rdata[CTRL_FORCE_BIT]    = q.force_rst;
               d.rdata[CTRL_MASK_BIT]     = q.done_irq_mask;
               d.rdata[CTRL_RST_BIT]      = usb_rst;
            end
            default: d.rdata = RESET_WORD;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) q <= '0;
      else          q <= d;
   end

   assign prdata  = q.rdata;
   assign irq_req = (q.ep0_done || q.ep1_rx_done || q.ep1_tx_done)
                    && q.done_irq_mask && !global_irq_disable;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup0;
      setup0 && !stall0;
   endsequence

   sequence s_ep0_both_nak;
      ep0_tx_state == ST_NAK && ep0_rx_state == ST_NAK;
   endsequence

   // a wrong data PID marks a resent packet whose acknowledge the host missed
   sequence s_rx1_repeat;
      ev_rx_ok && ev1 && ep1_rx_state == ST_VALID && ev_rx_pid != ep1_rx_toggle;
   endsequence

   sequence s_ep1_rx_hold;
      $stable(ep1_rx_toggle) && $stable(ep1_rx_state) && $stable(q.ep1_rx_done);
   endsequence

   // toggles
   setup_tx_toggle_a: assert property (s_setup0 |=> ep0_tx_toggle)
      else $error("SETUP did not set the ep0 transmit toggle");

   setup_rx_clear_a: assert property (s_setup0 |=> !ep0_rx_toggle)
      else $error("SETUP did not clear the ep0 receive toggle");

   tx_ack_flip_a: assert property (tx1_ok && !wr_ep1_tx |=>
                                   ep1_tx_toggle != $past(ep1_tx_toggle)
                                   && ep1_tx_state == ST_NAK && q.ep1_tx_done)
      else $error("ep1 ACK did not flip toggle, NAK and flag");

   ep0_tx_hold_a: assert property (!tx0_ok && !setup0 && !wr_ep0 && !usb_rst
                                   |=> $stable(ep0_tx_toggle))
      else $error("ep0 transmit toggle moved without ACK or SETUP");

   ep1_tx_hold_a: assert property (!tx1_ok && !wr_ep1_tx && !usb_rst
                                   |=> $stable(ep1_tx_toggle))
      else $error("ep1 transmit toggle moved without ACK");

   rx_toggle_cause_a: assert property ($changed(ep1_rx_toggle) |->
                                       $past(rx1_ok || wr_ep1_rx || usb_rst))
      else $error("ep1 receive toggle changed without cause");

   rx_repeat_hold_a: assert property (s_rx1_repeat ##0 !wr_ep1_rx |=> s_ep1_rx_hold)
      else $error("ep1 repeated packet changed receive fields");

   // state fields
   setup_nak_both_a: assert property (s_setup0 |=> s_ep0_both_nak)
      else $error("SETUP did not NAK both ep0 directions");

   setup_disabled_a: assert property (ev_setup && ev0 && ep0_rx_state == ST_DISABLED
                                      && !wr_ep0 && !stall0 |=> ep0_rx_state == ST_DISABLED)
      else $error("disabled ep0 reacted to a SETUP");

   ep0_xfer_nak_a: assert property (ep0_xfer_ok && !stall0 |=> s_ep0_both_nak ##0 q.ep0_done)
      else $error("ep0 correct transfer missed NAK or done flag");

   stall_both_a: assert property (stall0 |=> ep0_tx_state == ST_STALL
                                  && ep0_rx_state == ST_STALL)
      else $error("STALL answer did not stall both ep0 directions");

   rx1_only_rx_a: assert property (rx1_ok && !tx1_ok && !wr_ep1_tx |=>
                                   ep1_rx_state == ST_NAK && q.ep1_rx_done
                                   && $stable(ep1_tx_state))
      else $error("ep1 reception touched transmit state or missed NAK");

   tx1_only_tx_a: assert property (tx1_ok && !rx1_ok && !wr_ep1_rx |=>
                                   ep1_tx_state == ST_NAK && $stable(ep1_rx_state))
      else $error("ep1 transmission touched receive state or missed NAK");

   // done flags
   done_sticky_a: assert property (q.ep1_rx_done && !wr_ep1_rx |=> q.ep1_rx_done)
      else $error("ep1 receive done flag dropped without a write");

   done_clear_a: assert property (wr_ep1_rx && !pwdata[EP1_DONE_BIT] && !rx1_ok
                                  |=> !q.ep1_rx_done)
      else $error("writing zero did not clear the ep1 receive done flag");

   ep0_done_clear_a: assert property (wr_ep0 && !pwdata[EP0_DONE_BIT] && !ep0_xfer_ok
                                      |=> !q.ep0_done)
      else $error("writing zero did not clear the ep0 done flag");

   set_wins_a: assert property (tx1_ok && wr_ep1_tx && !pwdata[EP1_DONE_BIT]
                                |=> q.ep1_tx_done)
      else $error("clear beat a same-cycle transmit done event");

   // read path
   reserved_zero_a: assert property ($past(setup_ph) && sel != SEL_CTRL
                                     |-> prdata[31:8] == '0 && !(q.rdata[3] && $past(sel) == SEL_EP0))
      else $error("reserved read bits not zero");

   ep1_reserved_a: assert property ($past(setup_ph) && ($past(sel) == SEL_EP1_RX
                                    || $past(sel) == SEL_EP1_TX) |-> prdata[7:4] == 4'h0)
      else $error("ep1 reserved read bits not zero");

   // usb reset and interrupt gate
   usb_rst_ep0_a: assert property (usb_rst |=> ep0_tx_state == ST_DISABLED
                                   && ep0_rx_state == ST_DISABLED && !ep0_tx_toggle)
      else $error("usb reset did not clear ep0 fields");

   usb_rst_ep1_a: assert property (usb_rst |=> ep1_tx_state == ST_DISABLED
                                   && ep1_rx_state == ST_DISABLED
                                   && !ep1_tx_toggle && !ep1_rx_toggle)
      else $error("usb reset did not clear ep1 fields");

   irq_gate_a: assert property (irq_req |-> q.done_irq_mask && !global_irq_disable)
      else $error("interrupt raised while masked or disabled");

endmodule // usb_endpoint_handshake_ctrl

// ---- verification/usb_host_model.sv ----
// far-side engine model: turns one bench command into one-cycle event pulses
`timescale 1ns/1ps
module usb_host_model (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // command from the bench
   input  wire logic       go,
   input  wire logic [1:0] kind,
   input  wire logic       ep,
   input  wire logic       pid,
   // pulses toward the block
   output logic            ev_ep,
   output logic            ev_setup,
   output logic            ev_rx_ok,
   output logic            ev_rx_pid,
   output logic            ev_tx_ack,
   output logic            ev_stall_sent
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_setup      <= 1'h0;
         ev_rx_ok      <= 1'h0;
         ev_tx_ack     <= 1'h0;
         ev_stall_sent <= 1'h0;
         ev_ep         <= 1'h0;
         ev_rx_pid     <= 1'h0;
      end else begin
         // only one pulse per cycle, as the engine would give
         ev_setup      <= go && kind == 2'h0;
         ev_rx_ok      <= go && kind == 2'h1;
         ev_tx_ack     <= go && kind == 2'h2;
         ev_stall_sent <= go && kind == 2'h3;
         // outside a pulse the qualifiers wiggle, so a stale value never helps
         ev_ep         <= go ? ep : ~ev_ep;
         ev_rx_pid     <= go ? pid : ~ev_rx_pid;
      end
   end
endmodule // usb_host_model

// ---- verification/usb_endpoint_handshake_ctrl_tb.sv ----
// self-checking bench for the endpoint handshake control block
`timescale 1ns/1ps
module usb_endpoint_handshake_ctrl_tb;
   import usb_ep_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        usb_bus_reset, global_irq_disable, irq_req, iface_reset;
   logic        go, ep, pid, ev_ep, ev_setup, ev_rx_ok, ev_rx_pid;
   logic        ev_tx_ack, ev_stall_sent;
   logic [1:0]  kind, ep0_tx_state, ep0_rx_state, ep1_tx_state, ep1_rx_state;
   logic        ep0_tx_toggle, ep0_rx_toggle, ep1_tx_toggle, ep1_rx_toggle;
   int          n_errors, comparisons;

   usb_endpoint_handshake_ctrl usb_endpoint_handshake_ctrl_inst (.*);
   usb_host_model usb_host_model_inst (.pclk(pclk), .presetn(presetn), .go(go),
      .kind(kind), .ep(ep), .pid(pid), .ev_ep(ev_ep), .ev_setup(ev_setup),
      .ev_rx_ok(ev_rx_ok), .ev_rx_pid(ev_rx_pid), .ev_tx_ack(ev_tx_ack),
      .ev_stall_sent(ev_stall_sent));

   always #2.5 pclk = ~pclk;

   task automatic stop_test();
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) begin
         n_errors++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'h1, a, {24'h0, d}, r, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'h0, a, 32'h0, r, e);
      chk(r, exp);
   endtask

   // kind: 0 setup, 1 good reception, 2 host ack, 3 stall answered
   task automatic ev(input logic [1:0] k, input logic e, input logic p);
      @(posedge pclk);
      go   <= 1'h1;
      kind <= k;
      ep   <= e;
      pid  <= p;
      @(posedge pclk);
      go <= 1'h0;
      @(posedge pclk);
      #1;
   endtask

   function automatic logic [31:0] ep0_view();
      return {26'h0, ep0_tx_state, ep0_tx_toggle, ep0_rx_state, ep0_rx_toggle};
   endfunction

   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      rd_chk(OFS_EP0, 32'h0);
      rd_chk(OFS_EP1_RX, 32'h0);
      rd_chk(OFS_EP1_TX, 32'h0);
      apb(1'h0, 8'h10, 32'h0, r, e);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask

   task automatic t_sw();
      wr(OFS_EP0, 8'hff);
      rd_chk(OFS_EP0, 32'h77);
      chk(ep0_view(), 32'h3f);
      wr(OFS_EP1_RX, 8'hff);
      rd_chk(OFS_EP1_RX, 32'h07);
      wr(OFS_EP1_TX, 8'hf6);
      rd_chk(OFS_EP1_TX, 32'h06);
      for (int s = 0; s < 4; s++) begin
         wr(OFS_EP1_RX, 8'(s));
         #1;
         chk({30'h0, ep1_rx_state}, 32'(s));
      end
   endtask

   task automatic t_setup();
      wr(OFS_EP0, 8'h07);
      ev(2'h0, 1'h0, 1'h0);
      chk(ep0_view(), 32'h2c);
      // receive side disabled: the setup must leave everything alone
      wr(OFS_EP0, 8'h74);
      ev(2'h0, 1'h0, 1'h0);
      chk(ep0_view(), 32'h39);
      wr(OFS_EP0, 8'h33);
      ev(2'h3, 1'h0, 1'h0);
      chk(ep0_view(), 32'h12);
      wr(OFS_EP0, 8'h33);
      ev(2'h2, 1'h0, 1'h0);
      rd_chk(OFS_EP0, 32'he2);
      wr(OFS_EP0, 8'h03);
      ev(2'h1, 1'h0, 1'h0);
      rd_chk(OFS_EP0, 32'ha6);
   endtask

   task automatic t_ep1();
      wr(OFS_EP1_RX, 8'h03);
      wr(OFS_EP1_TX, 8'h03);
      ev(2'h1, 1'h1, 1'h1);
      rd_chk(OFS_EP1_RX, 32'h03);
      ev(2'h1, 1'h1, 1'h0);
      rd_chk(OFS_EP1_RX, 32'h0e);
      rd_chk(OFS_EP1_TX, 32'h03);
      wr(OFS_EP1_RX, 8'h07);
      ev(2'h1, 1'h1, 1'h1);
      rd_chk(OFS_EP1_RX, 32'h0a);
      wr(OFS_EP1_TX, 8'h07);
      ev(2'h2, 1'h1, 1'h0);
      rd_chk(OFS_EP1_TX, 32'h0a);
      rd_chk(OFS_EP1_RX, 32'h0a);
      ev(2'h2, 1'h1, 1'h0);
      rd_chk(OFS_EP1_TX, 32'h0a);
      chk({26'h0, ep1_tx_state, ep1_tx_toggle, ep1_rx_state, ep1_rx_toggle}, 32'h24);
      // ACK lands on the same edge as a write that clears the flag
      wr(OFS_EP1_TX, 8'h0b);
      fork
         wr(OFS_EP1_TX, 8'h03);
         ev(2'h2, 1'h1, 1'h0);
      join
      rd_chk(OFS_EP1_TX, 32'h0e);
   endtask

   task automatic t_irq();
      #1;
      chk({31'h0, irq_req}, 32'h0);
      wr(OFS_CTRL, 8'h02);
      #1;
      chk({31'h0, irq_req}, 32'h1);
      @(posedge pclk);
      global_irq_disable <= 1'h1;
      #1;
      chk({31'h0, irq_req}, 32'h0);
      @(posedge pclk);
      global_irq_disable <= 1'h0;
      wr(OFS_EP0, 8'h00);
      wr(OFS_EP1_RX, 8'h00);
      wr(OFS_EP1_TX, 8'h00);
      #1;
      chk({31'h0, irq_req}, 32'h0);
   endtask

   task automatic t_usb_reset();
      wr(OFS_EP0, 8'h33);
      ev(2'h2, 1'h0, 1'h0);
      wr(OFS_EP1_RX, 8'h07);
      wr(OFS_CTRL, 8'h01);
      #1;
      chk({31'h0, iface_reset}, 32'h1);
      rd_chk(OFS_EP0, 32'h80);
      rd_chk(OFS_EP1_RX, 32'h0);
      rd_chk(OFS_CTRL, 32'h81);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_EP1_TX, 8'h07);
      @(posedge pclk);
      usb_bus_reset <= 1'h1;
      @(posedge pclk);
      @(posedge pclk);
      usb_bus_reset <= 1'h0;
      rd_chk(OFS_EP1_TX, 32'h0);
   endtask

   initial begin
      pclk = 1'h0;
      presetn = 1'h0;
      {psel, penable, pwrite, usb_bus_reset, global_irq_disable, go} = 6'h0;
      {ep, pid, kind, paddr, pwdata} = 44'h0;
      n_errors = 0;
      comparisons = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_reset();
      t_sw();
      t_setup();
      t_ep1();
      t_irq();
      t_usb_reset();
      stop_test();
   end
endmodule // usb_endpoint_handshake_ctrl_tb
